//--- src/backlight_dimming_control.sv
// Backlight dimming control: picks the dimming method, measures duty of the
// incoming pulse train, stops and latches after an over-long low pulse with method select low.
// Assumes pins are asynchronous, a Wishbone classic master, one 25 MHz clock.
// Behaviour
// - Backlight lit while on control high or open, dark while driven low.
// - Pulse dimming only with method select low and pulses present.
// - Pulse mode brightness follows high time over period of the pulse train.
// - Pulse low beyond 50ms while on control high stops driver and latches; the code stops only with method select low.
// - Stopped state holds despite resumed pulses until backlight supply cycles.
// - Full brightness at maximum setting, about one percent at minimum at 325 Hz.
`timescale 1ns/1ps
module backlight_dimming_control
	import dim_pkg::*;
#(
	parameter int unsigned STALL_CYCLES = dim_pkg::STALL_LOW_CYC
) (
	input  wire logic                   clk_i,
	input  wire logic                   rst_i,
	input  wire logic                   backlight_supply_i,
	input  wire logic                   backlight_on_ctl_i,
	input  wire logic                   dimming_method_sel_i,
	input  wire logic                   dimming_pulse_in_i,
	input  wire logic [dim_pkg::ANA_W-1:0] analog_dim_in_i,
	input  wire logic [31:0]            wb_adr_i,
	input  wire logic [31:0]            wb_dat_i,
	input  wire logic [3:0]             wb_sel_i,
	input  wire logic                   wb_we_i,
	input  wire logic                   wb_cyc_i,
	input  wire logic                   wb_stb_i,
	output logic      [31:0]            wb_dat_o,
	output logic                        wb_ack_o,
	output logic                        led_drive_o,
	output logic [dim_pkg::LEVEL_W-1:0] brightness_o,
	output logic                        irq_o
);
	import dim_pkg::*;

	// Pins pass two flip-flops before any logic reads them
	sync_if pins ();

	// Measurement, watchdog and register state
	logic                supply_s1_reg;
	logic                supply_s2_reg;
	logic                pulse_d_reg;
	logic [CNT_W-1:0]    high_cnt_reg;
	logic [CNT_W-1:0]    per_cnt_reg;
	logic [CNT_W-1:0]    high_last_reg;
	logic [CNT_W-1:0]    per_last_reg;
	logic [CNT_W-1:0]    low_cnt_reg;
	logic                pulses_seen_reg;
	logic                stopped_reg;
	logic [31:0]         ctrl_reg;
	logic [IRQ_W-1:0]    irq_stat_reg;
	logic [IRQ_W-1:0]    irq_mask_reg;
	logic [LEVEL_W-1:0]  duty_level_reg;
	dim_mode_t           mode_reg;
	dim_mode_t           mode_next;
	logic [LEVEL_W-1:0]  bright_next;

	pin_sync u_sync (
		.clk_i (clk_i),
		.rst_i (rst_i),
		.pins  (pins)
	);

	// Raw pins into the synchroniser
	assign pins.on_raw    = backlight_on_ctl_i;
	assign pins.sel_raw   = dimming_method_sel_i;
	assign pins.pulse_raw = dimming_pulse_in_i;

	// Supply presence synchronised separately; its loss clears the stop latch
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			supply_s1_reg <= 1'b0;
			supply_s2_reg <= 1'b0;
		end else begin
			supply_s1_reg <= backlight_supply_i;
			supply_s2_reg <= supply_s1_reg;
		end
	end

	// Edge and state decode
	wire on_w       = pins.on_sync & ctrl_reg[CTRL_ENABLE_BIT];
	wire rise_w     = pins.pulse_sync & ~pulse_d_reg;
	wire supply_w   = supply_s2_reg;
	wire stall_w    = on_w & supply_w & ~pins.pulse_sync
	                  & (low_cnt_reg >= CNT_W'(STALL_CYCLES));
	wire wb_req_w   = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	// A write lands at the edge where the master sees ack, not one edge early
	wire wb_wr_w    = wb_cyc_i & wb_stb_i & wb_ack_o & wb_we_i & wb_sel_i[0];
	wire [7:0] adr_w = wb_adr_i[7:0];
	wire wr_ctrl_w  = wb_wr_w & (adr_w == ADDR_CTRL);
	wire wr_istat_w = wb_wr_w & (adr_w == ADDR_IRQ_STAT);
	wire wr_imask_w = wb_wr_w & (adr_w == ADDR_IRQ_MASK);
	wire stop_ev_w  = stall_w & ~stopped_reg & ~pins.sel_sync;
	wire per_ev_w   = rise_w & pulses_seen_reg;

	// Event and clear vectors of the sticky status, one bit per event
	logic [IRQ_W-1:0] irq_set_w;
	logic [IRQ_W-1:0] irq_clr_w;
	always_comb begin
		irq_set_w                 = '0;
		irq_set_w[IRQ_STOP_BIT]   = stop_ev_w;
		irq_set_w[IRQ_PERIOD_BIT] = per_ev_w;
	end
	assign irq_clr_w = wr_istat_w ? wb_dat_i[IRQ_W-1:0] : '0;

	// Previous sample of the synchronised pulse, for edge detection
	always_ff @(posedge clk_i) begin
		if (rst_i)
			pulse_d_reg <= 1'b0;
		else
			pulse_d_reg <= pins.pulse_sync;
	end

	// Period counter, restarted at each rising edge, saturating
	always_ff @(posedge clk_i) begin
		if (rst_i)
			per_cnt_reg <= '0;
		else if (rise_w)
			per_cnt_reg <= CNT_W'(1);
		else if (per_cnt_reg != '1)
			per_cnt_reg <= per_cnt_reg + CNT_W'(1);
	end

	// High-time counter, advances only while the line is high
	always_ff @(posedge clk_i) begin
		if (rst_i)
			high_cnt_reg <= '0;
		else if (rise_w)
			high_cnt_reg <= CNT_W'(1);
		else if (pins.pulse_sync && high_cnt_reg != '1)
			high_cnt_reg <= high_cnt_reg + CNT_W'(1);
	end

	// Last complete period captured at each rising edge
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			high_last_reg   <= '0;
			per_last_reg    <= '0;
			pulses_seen_reg <= 1'b0;
		end else if (rise_w) begin
			per_last_reg    <= per_cnt_reg;
			high_last_reg   <= high_cnt_reg;
			pulses_seen_reg <= 1'b1;
		end
	end

	// Duty to brightness: level = high * max / period, once per period
	wire [CNT_W+LEVEL_W-1:0] scaled_w = high_last_reg * LEVEL_MAX;
	wire [CNT_W+LEVEL_W-1:0] quot_w   = (per_last_reg == '0) ? '0
	                                    : scaled_w / per_last_reg;
	wire [LEVEL_W-1:0] duty_w = (quot_w > LEVEL_MAX) ? LEVEL_MAX
	                            : quot_w[LEVEL_W-1:0];

	// Duty level held between captures
	always_ff @(posedge clk_i) begin
		if (rst_i)
			duty_level_reg <= '0;
		else
			duty_level_reg <= duty_w;
	end

	// Low-time watchdog, counts while the line is low and the light is on
	always_ff @(posedge clk_i) begin
		if (rst_i)
			low_cnt_reg <= '0;
		else if (pins.pulse_sync || !on_w)
			low_cnt_reg <= '0;
		else if (low_cnt_reg != '1)
			low_cnt_reg <= low_cnt_reg + CNT_W'(1);
	end

	// Stop latch; only loss of the backlight supply releases it
	always_ff @(posedge clk_i) begin
		if (rst_i)
			stopped_reg <= 1'b0;
		else if (!supply_w)
			stopped_reg <= 1'b0;
		else if (stall_w && !pins.sel_sync)
			stopped_reg <= 1'b1;
	end

	// Mode selection
	always_comb begin
		mode_next = MODE_DARK;
		case (1'b1)
			!supply_w || !on_w: mode_next = MODE_DARK;
			stopped_reg:        mode_next = MODE_STOPPED;
			!pins.sel_sync:     mode_next = MODE_PULSE;
			default:            mode_next = MODE_ANALOG;
		endcase
	end

	// Brightness per mode
	always_comb begin
		bright_next = '0;
		case (mode_next)
			MODE_DARK:    bright_next = '0;
			MODE_STOPPED: bright_next = '0;
			MODE_PULSE:   bright_next = pulses_seen_reg ? duty_level_reg : '0;
			MODE_ANALOG:  bright_next = analog_dim_in_i;
			default:      bright_next = '0;
		endcase
	end

	// Lit in pulse or analog mode only
	wire led_on_w = (mode_next == MODE_PULSE) || (mode_next == MODE_ANALOG);

	// Registered mode, reported in the status register
	always_ff @(posedge clk_i) begin
		if (rst_i)
			mode_reg <= MODE_DARK;
		else
			mode_reg <= mode_next;
	end

	// LED driver enable, on only in a lit mode
	always_ff @(posedge clk_i) begin
		if (rst_i)
			led_drive_o <= 1'b0;
		else
			led_drive_o <= led_on_w;
	end

	// Brightness output, zero whenever the driver is off
	always_ff @(posedge clk_i) begin
		if (rst_i)
			brightness_o <= '0;
		else
			brightness_o <= bright_next;
	end

	// Control register; only the enable bit is kept
	always_ff @(posedge clk_i) begin
		if (rst_i)
			ctrl_reg <= CTRL_RESET_VAL;
		else if (wr_ctrl_w)
			ctrl_reg <= {31'h0, wb_dat_i[CTRL_ENABLE_BIT]};
	end

	// Interrupt mask, same layout as the status
	always_ff @(posedge clk_i) begin
		if (rst_i)
			irq_mask_reg <= '0;
		else if (wr_imask_w)
			irq_mask_reg <= wb_dat_i[IRQ_W-1:0];
	end

	// Sticky status, write one to clear; a set beats a same-cycle clear
	always_ff @(posedge clk_i) begin
		if (rst_i)
			irq_stat_reg <= '0;
		else
			irq_stat_reg <= (irq_stat_reg & ~irq_clr_w) | irq_set_w;
	end

	// Status word: pin levels, stop latch and current mode
	wire [31:0] status_w = {26'h0, pins.pulse_sync, pins.sel_sync, pins.on_sync,
	                        stopped_reg, mode_reg};

	// Read mux
	logic [31:0] rd_w;
	always_comb begin
		rd_w = 32'h0;
		case (adr_w)
			ADDR_CTRL:     rd_w = ctrl_reg;
			ADDR_STATUS:   rd_w = status_w;
			ADDR_IRQ_STAT: rd_w = {30'h0, irq_stat_reg};
			ADDR_IRQ_MASK: rd_w = {30'h0, irq_mask_reg};
			ADDR_LEVEL:    rd_w = {24'h0, brightness_o};
			ADDR_PERIOD:   rd_w = {8'h0, per_last_reg};
			default:       rd_w = 32'h0;
		endcase
	end

	// Wishbone classic slave: ack one cycle after the request, for one cycle
	always_ff @(posedge clk_i) begin
		if (rst_i)
			wb_ack_o <= 1'b0;
		else
			wb_ack_o <= wb_req_w;
	end

	// Read data stands with ack only, zero otherwise
	always_ff @(posedge clk_i) begin
		if (rst_i)
			wb_dat_o <= 32'h0;
		else
			wb_dat_o <= wb_req_w ? rd_w : 32'h0;
	end

	// Level interrupt, high while an unmasked status bit is set
	always_ff @(posedge clk_i) begin
		if (rst_i)
			irq_o <= 1'b0;
		else
			irq_o <= |(irq_stat_reg & irq_mask_reg);
	end
endmodule

//--- src/dim_pkg.sv
// Constants and types shared by the backlight dimming control block.
// Assumes a single 25 MHz clock domain; the top module, the checker and the bench import it.
package dim_pkg;
	// Clock rate and timing
	localparam int unsigned CLK_HZ            = 25000000;
	localparam int unsigned STALL_LOW_MS      = 50;
	localparam int unsigned STALL_LOW_CYC     = CLK_HZ / 1000 * STALL_LOW_MS;
	localparam int unsigned FULL_SCALE_HZ     = 325;
	localparam int unsigned CNT_W             = 24;
	localparam int unsigned LEVEL_W           = 8;
	localparam int unsigned ANA_W             = 8;

	// Register map, byte addresses
	localparam logic [7:0] ADDR_CTRL     = 8'h00;
	localparam logic [7:0] ADDR_STATUS   = 8'h04;
	localparam logic [7:0] ADDR_IRQ_STAT = 8'h08;
	localparam logic [7:0] ADDR_IRQ_MASK = 8'h0c;
	localparam logic [7:0] ADDR_LEVEL    = 8'h10;
	localparam logic [7:0] ADDR_PERIOD   = 8'h14;

	// Control register fields
	localparam int unsigned CTRL_ENABLE_BIT = 0;
	localparam logic [31:0] CTRL_RESET_VAL  = 32'h0000_0001;

	// Interrupt status bits
	localparam int unsigned IRQ_STOP_BIT   = 0;
	localparam int unsigned IRQ_PERIOD_BIT = 1;
	localparam int unsigned IRQ_W          = 2;

	// Brightness full scale
	localparam logic [LEVEL_W-1:0] LEVEL_MAX = 8'hff;

	typedef enum logic [1:0] {
		MODE_DARK,
		MODE_PULSE,
		MODE_ANALOG,
		MODE_STOPPED
	} dim_mode_t;
endpackage

//--- src/sync_if.sv
// Carrier between the top module and its input synchroniser.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
interface sync_if;
	logic on_raw;
	logic sel_raw;
	logic pulse_raw;
	logic on_sync;
	logic sel_sync;
	logic pulse_sync;
	modport top  (output on_raw, sel_raw, pulse_raw, input on_sync, sel_sync, pulse_sync);
	modport sync (input on_raw, sel_raw, pulse_raw, output on_sync, sel_sync, pulse_sync);
endinterface

//--- src/pin_sync.sv
// Two flip-flop synchroniser for the three control pins.
// Assumes the pins are asynchronous to clk_i.
`timescale 1ns/1ps
module pin_sync (
	input  wire logic clk_i,
	input  wire logic rst_i,
	sync_if.sync      pins
);
	logic [2:0] stage1_reg;
	logic [2:0] stage2_reg;

	// Two stages; only the second is read outside
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			stage1_reg <= 3'h0;
			stage2_reg <= 3'h0;
		end else begin
			stage1_reg <= {pins.on_raw, pins.sel_raw, pins.pulse_raw};
			stage2_reg <= stage1_reg;
		end
	end

	assign pins.on_sync    = stage2_reg[2];
	assign pins.sel_sync   = stage2_reg[1];
	assign pins.pulse_sync = stage2_reg[0];
endmodule

//--- test/dim_sva.sv
// Port checker for the dimming block.
// Assumes it is bound to the top module with its stall count.
`timescale 1ns/1ps
module dim_sva
	import dim_pkg::*;
#(
	parameter int unsigned STALL_CYCLES = 200
) (
	input wire logic             clk_i,
	input wire logic             rst_i,
	input wire logic             backlight_supply_i,
	input wire logic             backlight_on_ctl_i,
	input wire logic             dimming_method_sel_i,
	input wire logic             dimming_pulse_in_i,
	input wire logic [ANA_W-1:0] analog_dim_in_i,
	input wire logic             wb_cyc_i,
	input wire logic             wb_stb_i,
	input wire logic [31:0]      wb_dat_o,
	input wire logic             wb_ack_o,
	input wire logic             led_drive_o,
	input wire logic [LEVEL_W-1:0] brightness_o,
	input wire logic             irq_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	logic [31:0] stall_cnt;
	// Cycles of low pulse line while pulse dimming is armed
	always_ff @(posedge clk_i) begin
		if (rst_i || dimming_pulse_in_i || !backlight_on_ctl_i || dimming_method_sel_i
			|| !backlight_supply_i) begin
			stall_cnt <= '0;
		end else if (stall_cnt < STALL_CYCLES + 8) begin
			stall_cnt <= stall_cnt + 32'h1;
		end
	end
	sequence s_req;
		wb_cyc_i && wb_stb_i && !wb_ack_o;
	endsequence
	sequence s_off_held;
		!backlight_on_ctl_i [*6];
	endsequence
	sequence s_analog_held;
		(dimming_method_sel_i && $stable(analog_dim_in_i)) [*6];
	endsequence
	a_ack_follows_req: assert property (s_req |=> wb_ack_o)
		else $error("ack missing after request");
	a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack held two cycles");
	a_no_stray_ack: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
		else $error("ack without request");
	a_rdata_idle_zero: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
		else $error("read data not zero outside ack");
	a_reset_outputs_low: assert property (@(posedge clk_i) disable iff (1'b0)
		rst_i |=> !led_drive_o && !irq_o && !wb_ack_o) else $error("outputs active after reset");
	a_off_is_dark: assert property (s_off_held |-> !led_drive_o)
		else $error("driving while off control low");
	a_stall_stops: assert property (stall_cnt >= STALL_CYCLES + 8 |-> !led_drive_o)
		else $error("driver still on after long low pulse");
	a_analog_level: assert property (s_analog_held ##0 led_drive_o
		|-> brightness_o == analog_dim_in_i) else $error("analog level not followed");
endmodule
bind backlight_dimming_control dim_sva #(.STALL_CYCLES(STALL_CYCLES)) dim_sva_u (
	.clk_i(clk_i), .rst_i(rst_i), .backlight_supply_i(backlight_supply_i),
	.backlight_on_ctl_i(backlight_on_ctl_i), .dimming_method_sel_i(dimming_method_sel_i),
	.dimming_pulse_in_i(dimming_pulse_in_i), .analog_dim_in_i(analog_dim_in_i),
	.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
	.led_drive_o(led_drive_o), .brightness_o(brightness_o), .irq_o(irq_o));

//--- test/host_dim_model.sv
// Host model: drives the dimming pulse train.
// Assumes period and high time in clocks, scaled down for simulation.
`timescale 1ns/1ps
module host_dim_model (
	input  wire logic        clk_i,
	input  wire logic        run_i,
	input  wire logic [15:0] period_i,
	input  wire logic [15:0] high_i,
	output logic             pulse_o
);
	logic [15:0] phase_reg;
	// Period counter; line driven low while stopped
	always_ff @(posedge clk_i) begin
		if (!run_i || phase_reg >= period_i - 16'h1) begin
			phase_reg <= '0;
		end else begin
			phase_reg <= phase_reg + 16'h1;
		end
		pulse_o <= run_i && (phase_reg < high_i);
	end
endmodule

//--- test/backlight_dimming_control_test.sv
// Bench for the dimming block: bus tasks, pin stimulus, host model.
// Assumes a 25 MHz clock and a shortened stall count.
`timescale 1ns/1ps
module backlight_dimming_control_test;
	import dim_pkg::*;
	localparam int unsigned STALL = 200;
	logic clk_i = 0, rst_i = 1, sup = 1, on = 1, sel = 1, run = 0, cyc = 0, stb = 0, we = 0;
	logic [7:0]  ana = 8'h5a;
	logic [31:0] adr = '0, dat = '0, rdat, dat_o;
	logic [15:0] per = 16'h64, hi = 16'h19;
	logic        ack, led, irq, pulse;
	logic [7:0]  bri;
	int          errors = 0, n_checks = 0, ticks = 0;
	backlight_dimming_control #(.STALL_CYCLES(STALL)) dut_u (.clk_i(clk_i), .rst_i(rst_i),
		.backlight_supply_i(sup), .backlight_on_ctl_i(on), .dimming_method_sel_i(sel),
		.dimming_pulse_in_i(pulse), .analog_dim_in_i(ana), .wb_adr_i(adr), .wb_dat_i(dat),
		.wb_sel_i(4'hf), .wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_dat_o(dat_o),
		.wb_ack_o(ack), .led_drive_o(led), .brightness_o(bri), .irq_o(irq));
	host_dim_model host_u (.clk_i(clk_i), .run_i(run), .period_i(per), .high_i(hi),
		.pulse_o(pulse));
	always #20 clk_i = ~clk_i;
	task automatic tally_and_finish();
		$display("checks %0d errors %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	// Hang guard
	always @(posedge clk_i) begin
		ticks <= ticks + 1;
		if (ticks == 20000) begin
			errors++;
			tally_and_finish();
		end
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			errors++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	// Classic single cycle, held until ack is sampled
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_i);
		cyc <= 1;
		stb <= 1;
		we <= w;
		adr <= {24'h0, a};
		dat <= d;
		do begin
			@(posedge clk_i);
		end while (ack !== 1'b1);
		rdat = dat_o;
		cyc <= 0;
		stb <= 0;
		we <= 0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		wb(1'b0, a, 32'h0);
		chk(rdat, exp);
	endtask
	task automatic hold(input int n);
		repeat (n) @(posedge clk_i);
	endtask
	initial begin
		hold(2);
		rst_i <= 0;
		rd(ADDR_CTRL, CTRL_RESET_VAL);
		rd(ADDR_IRQ_MASK, 32'h0);
		rd(8'h20, 32'h0);
		hold(10);
		rd(ADDR_LEVEL, 32'h5a);
		chk({31'h0, led}, 32'h1);
		ana <= 8'hc3;
		hold(4);
		chk({24'h0, bri}, 32'hc3);
		on <= 0;
		sel <= 0;
		hold(10);
		chk({31'h0, led}, 32'h0);
		rd(ADDR_STATUS, 32'h0);
		on <= 1;
		run <= 1;
		hold(400);
		rd(ADDR_PERIOD, 32'h64);
		rd(ADDR_LEVEL, 32'h3f);
		hi <= 16'h4b;
		hold(400);
		chk({24'h0, bri}, 32'hbf);
		wb(1'b1, ADDR_IRQ_MASK, 32'h1);
		run <= 0;
		hold(STALL + 20);
		chk({30'h0, irq, led}, 32'h2);
		rd(ADDR_STATUS, 32'h0f);
		rd(ADDR_IRQ_STAT, 32'h3);
		run <= 1;
		hold(400);
		chk({23'h0, led, bri}, 32'h0);
		wb(1'b1, ADDR_IRQ_STAT, 32'h3);
		hold(3);
		chk({31'h0, irq}, 32'h0);
		sup <= 0;
		hold(10);
		sup <= 1;
		hold(400);
		chk({23'h0, led, bri}, 32'h1bf);
		wb(1'b1, ADDR_CTRL, 32'h0);
		hold(3);
		chk({23'h0, led, bri}, 32'h0);
		rd(ADDR_CTRL, 32'h0);
		tally_and_finish();
	end
endmodule
